// >>> core/sdcpm_top.v
// sdram command decode, auto-precharge and power mode core
`timescale 1ns/1ps
`default_nettype none
`include "sdcpm_defs.vh"
module sdcpm_top (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        cs_n,
   input  wire        ras_n,
   input  wire        cas_n,
   input  wire        we_n,
   input  wire        cke,
   input  wire        bank_select_low,
   input  wire        bank_select_high,
   input  wire [11:0] addr,
   input  wire [2:0]  burst_len_cfg,
   input  wire        interleave_cfg,
   input  wire [1:0]  cas_latency_cfg,
   input  wire        col_ready,
   output reg         col_valid,
   output reg  [1:0]  col_bank,
   output reg  [8:0]  col_addr,
   output reg         col_is_write,
   output reg  [3:0]  bank_open,
   output reg  [3:0]  bank_precharging,
   output reg  [1:0]  power_mode,
   output reg         burst_busy,
   output reg         mode_set_pulse,
   output reg         refresh_pulse
);
   // ***************************************************
   // input synchronisers
   // ***************************************************
   reg  [16:0] s1_r;
   reg  [16:0] s2_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 17'h1ffff;
         s2_r <= 17'h1ffff;
      end else begin
         s1_r <= {cke, cs_n, ras_n, cas_n, we_n, bank_select_high,
                  bank_select_low, addr[9:0]};
         s2_r <= s1_r;
      end
   end
   wire        gate_now  = s2_r[16];
   wire [3:0]  pins      = s2_r[15:12];
   wire [1:0]  bank_in   = s2_r[11:10];
   wire [9:0]  addr_in   = s2_r[9:0];
   reg  [1:0]  a10_s1_r;
   reg  [1:0]  a10_s2_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a10_s1_r <= 2'h0;
         a10_s2_r <= 2'h0;
      end else begin
         a10_s1_r <= {addr[11], addr[10]};
         a10_s2_r <= a10_s1_r;
      end
   end
   wire precharge_flag_address_bit = a10_s2_r[0];

   // ***************************************************
   // command qualification and decode
   // ***************************************************
   reg  prior_cycle_gate_level_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prior_cycle_gate_level_r <= 1'b1;
      end else begin
         prior_cycle_gate_level_r <= gate_now;
      end
   end
   // deselect folds to nop [R17]
   wire [3:0] cmd = pins[3] ? `SDCPM_CMD_NOP : {1'b0, pins[2:0]};
   wire       live = prior_cycle_gate_level_r &&
                     power_mode == `SDCPM_MD_NORMAL; // [R19] [R12]
   wire is_act = live && cmd == `SDCPM_CMD_ACT;   // [R20]
   wire is_rd  = live && cmd == `SDCPM_CMD_RD;    // [R20]
   wire is_wr  = live && cmd == `SDCPM_CMD_WR;    // [R20]
   wire is_mrs = live && cmd == `SDCPM_CMD_MRS;   // [R20]
   wire is_bst = live && cmd == `SDCPM_CMD_BST;   // [R20]
   wire is_pre = live && cmd == `SDCPM_CMD_PRE;   // [R8]
   wire is_ref = live && cmd == `SDCPM_CMD_REF && gate_now;  // [R20]
   wire is_sr  = live && cmd == `SDCPM_CMD_REF && !gate_now; // [R11]

   // ***************************************************
   // burst engine
   // ***************************************************
   reg  [8:0] start_r;
   reg  [8:0] beat_r;
   reg  [8:0] blen_r;
   reg  [1:0] bbank_r;
   reg        bwrite_r;
   reg        bap_r;
   reg        bfull_r;
   reg        frozen_r;
   reg  [2:0] wr_ap_cnt_r;
   reg  [1:0] wr_ap_bank_r;
   reg        wr_ap_pend_r;
   reg  [3:0] open_nxt;
   reg  [3:0] pchg_nxt;
   wire       fifo_in_ready;
   wire       fifo_out_valid;
   wire [14:0] fifo_out_data;
   reg  [8:0] blen_dec;
   reg  [8:0] col_now;
   reg  [8:0] ap_lead;

   always @* begin
      case (burst_len_cfg)
         `SDCPM_BL1: blen_dec = 9'h001;
         `SDCPM_BL2: blen_dec = 9'h002;
         `SDCPM_BL4: blen_dec = 9'h004;
         `SDCPM_BL8: blen_dec = 9'h008;
         default:    blen_dec = 9'h000;
      endcase
   end

   // low start bits take the beat count by xor or by add with no carry
   always @* begin
      col_now = start_r;
      if (interleave_cfg && !bfull_r) begin
         col_now = start_r ^ (beat_r & (blen_r - 9'h001)); // [R1]
      end else if (bfull_r) begin
         col_now = start_r + beat_r;
      end else begin
         col_now = (start_r & ~(blen_r - 9'h001)) |
                   ((start_r + beat_r) & (blen_r - 9'h001));
      end
   end

   // read precharge lead is latency minus one (zero for latency 0), independent of length
   always @* begin
      ap_lead = {7'h00, cas_latency_cfg} - 9'h001; // [R3]
      if (cas_latency_cfg == 2'h0) begin
         ap_lead = 9'h000;
      end
   end

   wire stall   = frozen_r || !fifo_in_ready;
   wire beat_go = burst_busy && !stall;
   wire last    = beat_go && !bfull_r && beat_r == blen_r - 9'h001;
   // a lead as long as or longer than the burst starts precharge at the first beat
   wire rd_ap_now = beat_go && bap_r && !bwrite_r && !bfull_r &&
                    (beat_r + ap_lead == blen_r - 9'h001 ||
                     (beat_r == 9'h000 && ap_lead >= blen_r)); // [R3]

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_r      <= 9'h000;
         beat_r       <= 9'h000;
         blen_r       <= 9'h001;
         bbank_r      <= 2'h0;
         bwrite_r     <= 1'b0;
         bap_r        <= 1'b0;
         bfull_r      <= 1'b0;
         burst_busy   <= 1'b0;
         wr_ap_cnt_r  <= 3'h0;
         wr_ap_bank_r <= 2'h0;
         wr_ap_pend_r <= 1'b0;
      end else begin
         // nop leaves a running burst alone [R16]
         if ((is_rd || is_wr) && bank_open[bank_in]) begin
            start_r  <= addr_in[8:0];
            beat_r   <= 9'h000;
            blen_r   <= (burst_len_cfg == `SDCPM_BLFP) ? 9'h000 : blen_dec;
            bfull_r  <= (burst_len_cfg == `SDCPM_BLFP);
            bbank_r  <= bank_in;
            bwrite_r <= is_wr;
            bap_r    <= precharge_flag_address_bit; // [R2]
            burst_busy <= 1'b1;
         end else if (is_bst) begin
            burst_busy <= 1'b0;
         end else if (last) begin
            burst_busy <= 1'b0;
         end else if (beat_go) begin
            beat_r <= beat_r + 9'h001;
         end
         if (last && bap_r && bwrite_r) begin
            wr_ap_pend_r <= 1'b1;
            wr_ap_cnt_r  <= `SDCPM_WR_AP_DLY;
            wr_ap_bank_r <= bbank_r;
         end else if (wr_ap_pend_r && !frozen_r) begin
            wr_ap_cnt_r <= wr_ap_cnt_r - 3'h1;
            if (wr_ap_cnt_r == 3'h1) begin
               wr_ap_pend_r <= 1'b0; // [R6]
            end
         end
      end
   end
   wire wr_ap_now = wr_ap_pend_r && !frozen_r && wr_ap_cnt_r == 3'h1;

   // ***************************************************
   // bank state
   // ***************************************************
   always @* begin
      open_nxt = bank_open;
      pchg_nxt = 4'h0;
      if (is_act) begin
         open_nxt[bank_in] = 1'b1;
      end
      if (is_pre) begin
         if (precharge_flag_address_bit) begin
            pchg_nxt = bank_open; // [R9]
         end else begin
            pchg_nxt[bank_in] = bank_open[bank_in]; // [R9]
         end
      end
      if (rd_ap_now) begin
         pchg_nxt[bbank_r] = 1'b1; // [R2]
      end
      if (wr_ap_now) begin
         pchg_nxt[wr_ap_bank_r] = 1'b1; // [R6]
      end
      open_nxt = open_nxt & ~pchg_nxt;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_open        <= 4'h0;
         bank_precharging <= 4'h0;
         mode_set_pulse   <= 1'b0;
         refresh_pulse    <= 1'b0;
      end else begin
         bank_open        <= open_nxt;
         bank_precharging <= pchg_nxt;
         mode_set_pulse   <= is_mrs && bank_open == 4'h0;
         refresh_pulse    <= is_ref && bank_open == 4'h0;
      end
   end

   // ***************************************************
   // power modes
   // ***************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         power_mode <= `SDCPM_MD_NORMAL;
         frozen_r   <= 1'b0;
      end else begin
         case (power_mode)
            `SDCPM_MD_NORMAL: begin
               if (is_sr && bank_open == 4'h0) begin
                  power_mode <= `SDCPM_MD_SELFREF; // [R11]
               end else if (!gate_now && prior_cycle_gate_level_r) begin
                  if (burst_busy || bank_open != 4'h0) begin
                     power_mode <= `SDCPM_MD_SUSPEND; // [R22] [R18]
                  end else begin
                     power_mode <= `SDCPM_MD_PDOWN;
                  end
               end
            end
            `SDCPM_MD_SUSPEND: begin
               frozen_r <= 1'b1; // [R18]
               if (gate_now) begin
                  power_mode <= `SDCPM_MD_NORMAL;
               end
            end
            `SDCPM_MD_PDOWN: begin
               if (gate_now) begin
                  power_mode <= `SDCPM_MD_NORMAL;
               end
            end
            `SDCPM_MD_SELFREF: begin
               if (gate_now) begin
                  power_mode <= `SDCPM_MD_NORMAL; // [R12]
               end
            end
            default: begin
               power_mode <= `SDCPM_MD_NORMAL;
            end
         endcase
         if (power_mode != `SDCPM_MD_SUSPEND) begin
            frozen_r <= 1'b0; // [R18]
         end
      end
   end

   // ***************************************************
   // column address stream
   // ***************************************************
   sdcpm_fifo #(
      .W  (`SDCPM_FIFO_W),
      .D  (`SDCPM_FIFO_D),
      .AW (`SDCPM_FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (beat_go),
      .in_ready  (fifo_in_ready),
      .in_data   ({bbank_r, bwrite_r, bap_r, bfull_r, 1'b0, col_now}),
      .out_valid (fifo_out_valid),
      .out_ready (!col_valid || col_ready),
      .out_data  (fifo_out_data)
   );

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         col_valid    <= 1'b0;
         col_bank     <= 2'h0;
         col_addr     <= 9'h000;
         col_is_write <= 1'b0;
      end else if (!col_valid || col_ready) begin
         col_valid    <= fifo_out_valid;
         col_bank     <= fifo_out_data[14:13];
         col_is_write <= fifo_out_data[12];
         col_addr     <= fifo_out_data[8:0];
      end
   end
endmodule
`default_nettype wire

// >>> inc/sdcpm_defs.vh
// constants for the sdram command and power mode block
// What this block and its controller must do
// R1 - interleave burst column equals start address xor beat count, bursts 2, 4, 8
// R2 - precharge flag high on read or write selects auto-precharge after burst
// R3 - read auto-precharge starts a cas-latency-dependent count before burst end
// R4 - controller issues no read, write, precharge to bank in auto-precharge burst
// R5 - controller never requests auto-precharge with full page burst length
// R6 - write auto-precharge begins two clocks after last write beat
// R7 - controller keeps activate to internal precharge at least active_to_precharge_time
// R8 - cs, ras, we low and cas high decode as precharge
// R9 - precharge flag high closes all banks, else only selected bank
// R10 - controller waits precharge_time before reactivating, reactivates before access
// R11 - cs, ras, cas, gate low, we high enters self refresh, banks idle
// R12 - self refresh ignores all but gate, exits when gate returns high
// R13 - controller bursts 4,096 auto refreshes around self refresh
// R14 - gate low enters power down; controller exits within refresh_period
// R15 - controller presents nop after power down exit and holds gate high
// R16 - cs low with strobes and we high is nop, burst continues
// R17 - cs high behaves as nop regardless of strobes
// R18 - gate low with bank active freezes one clock later, resumes one later
// R19 - commands sampled on rising edge, decoded only if prior gate level high
// R20 - decode activate, read, write, mode set, burst stop, auto refresh patterns
// R21 - controller issues burst stop only during full page bursts
// R22 - gate lowered during burst enters clock suspend, not power down
// R23 - controller waits row_to_column_delay after activate before access
// R24 - controller tracks bank states and timing before each command
`ifndef SDCPM_DEFS_VH
`define SDCPM_DEFS_VH
`define SDCPM_CMD_ACT     4'h3
`define SDCPM_CMD_RD      4'h5
`define SDCPM_CMD_WR      4'h4
`define SDCPM_CMD_MRS     4'h0
`define SDCPM_CMD_BST     4'h6
`define SDCPM_CMD_REF     4'h1
`define SDCPM_CMD_PRE     4'h2
`define SDCPM_CMD_NOP     4'h7
`define SDCPM_BL1         3'h0
`define SDCPM_BL2         3'h1
`define SDCPM_BL4         3'h2
`define SDCPM_BL8         3'h3
`define SDCPM_BLFP        3'h7
`define SDCPM_WR_AP_DLY   3'h2
`define SDCPM_FIFO_W      15
`define SDCPM_FIFO_D      8
`define SDCPM_FIFO_AW     3
`define SDCPM_COL_W       9
`define SDCPM_MD_NORMAL   2'h0
`define SDCPM_MD_SUSPEND  2'h1
`define SDCPM_MD_PDOWN    2'h2
`define SDCPM_MD_SELFREF  2'h3
`endif

// >>> core/sdcpm_fifo.v
// parameterised valid/ready fifo for burst column addresses
`timescale 1ns/1ps
`default_nettype none
module sdcpm_fifo #(
   parameter W  = 15,
   parameter D  = 8,
   parameter AW = 3
) (
   input  wire          clk,
   input  wire          rst_n,
   input  wire          in_valid,
   output wire          in_ready,
   input  wire [W-1:0]  in_data,
   output wire          out_valid,
   input  wire          out_ready,
   output wire [W-1:0]  out_data
);
   reg  [W-1:0]  mem [0:D-1];
   reg  [AW-1:0] wp_r;
   reg  [AW-1:0] rp_r;
   reg  [AW:0]   cnt_r;
   wire          push;
   wire          pop;

   assign in_ready  = (cnt_r != D);
   assign out_valid = (cnt_r != 0);
   assign out_data  = mem[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         if (push & !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> bench/sdcpm_checker.sv
// concurrent checks on the command and power mode core ports
`timescale 1ns/1ps
`default_nettype none
`include "sdcpm_defs.vh"
module sdcpm_checker (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       col_ready,
   input wire logic       col_valid,
   input wire logic [1:0] col_bank,
   input wire logic [8:0] col_addr,
   input wire logic [3:0] bank_open,
   input wire logic [3:0] bank_precharging,
   input wire logic [1:0] power_mode,
   input wire logic       burst_busy,
   input wire logic       mode_set_pulse,
   input wire logic       refresh_pulse
);
   // **********
   // properties
   // **********
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_stall;
      col_valid && !col_ready;
   endsequence
   sequence s_frozen;
      power_mode != `SDCPM_MD_NORMAL ##1 power_mode != `SDCPM_MD_NORMAL;
   endsequence
   a_pre_closes: assert property ((bank_precharging != 4'h0) |=>
      ((bank_open & $past(bank_precharging)) == 4'h0))
      else $error("precharged bank still open");
   a_col_hold: assert property (s_stall |=> col_valid &&
      $stable(col_addr) && $stable(col_bank))
      else $error("column beat dropped while stalled");
   a_pulse_one: assert property ((mode_set_pulse || refresh_pulse) |=>
      !(mode_set_pulse || refresh_pulse))
      else $error("command pulse too long");
   a_pulse_idle: assert property ((mode_set_pulse || refresh_pulse) |->
      bank_open == 4'h0)
      else $error("mode set or refresh with a bank open");
   a_susp_open: assert property (power_mode == `SDCPM_MD_SUSPEND |->
      (bank_open != 4'h0 || burst_busy))
      else $error("clock suspend with nothing active");
   a_pdown_idle: assert property (power_mode == `SDCPM_MD_PDOWN |->
      (bank_open == 4'h0 && !burst_busy))
      else $error("power down inside a burst");
   a_sref_idle: assert property (power_mode == `SDCPM_MD_SELFREF |->
      bank_open == 4'h0)
      else $error("self refresh with a bank open");
   a_frozen_state: assert property (s_frozen |->
      $stable(bank_open) && bank_precharging == 4'h0)
      else $error("bank state moved while frozen");
endmodule
bind sdcpm_top sdcpm_checker sdcpm_checker_inst (.clk(clk), .rst_n(rst_n),
   .col_ready(col_ready), .col_valid(col_valid), .col_bank(col_bank),
   .col_addr(col_addr), .bank_open(bank_open),
   .bank_precharging(bank_precharging), .power_mode(power_mode),
   .burst_busy(burst_busy), .mode_set_pulse(mode_set_pulse),
   .refresh_pulse(refresh_pulse));
`default_nettype wire

// >>> bench/sdcpm_ctl_model.sv
// behavioural memory controller driving command pins and the column sink
`timescale 1ns/1ps
`default_nettype none
`include "sdcpm_defs.vh"
module sdcpm_ctl_model (
   input  wire logic        clk,
   input  wire logic        stall,
   output var  logic        cs_n,
   output var  logic        ras_n,
   output var  logic        cas_n,
   output var  logic        we_n,
   output var  logic        cke,
   output var  logic        bsl,
   output var  logic        bsh,
   output var  logic [11:0] addr,
   output var  logic        col_ready
);
   logic [31:0] seed = 32'h6ad0;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   initial begin
      {cs_n, ras_n, cas_n, we_n, cke, bsl, bsh} = 7'h7c;
      addr = 12'h000;
      col_ready = 1'b0;
   end
   // random sink stalls, held off while the bench wants a full fifo
   always @(negedge clk) begin
      seed <= lfsr(seed);
      col_ready <= !stall && seed[0];
   end
   // full page and burst stop are never used
   task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                      input logic [11:0] a, input int gap = 4,
                      input logic k = 1'b1);
      @(negedge clk);
      {cs_n, ras_n, cas_n, we_n} = c;
      {bsh, bsl} = b;
      addr = a;
      cke = k;
      @(negedge clk);
      {cs_n, ras_n, cas_n, we_n} = `SDCPM_CMD_NOP;
      addr = ~a;
      // idle gap covers bank and burst delays
      repeat (gap) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the sdram command and power mode core
`timescale 1ns/1ps
`default_nettype none
`include "sdcpm_defs.vh"
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, stall = 1'b1;
   logic        cs_n, ras_n, cas_n, we_n, cke, bsl, bsh, col_ready;
   logic [11:0] addr;
   logic [2:0]  bl_cfg = `SDCPM_BL4;
   logic [1:0]  cl_cfg = 2'h3, col_bank, power_mode;
   logic        col_valid, col_is_write, burst_busy, ms_p, rf_p;
   logic [8:0]  col_addr;
   logic [3:0]  bank_open, bank_pre, n_ms = 0, n_rf = 0, pre_seen = 0;
   logic [11:0] exp_q[$];
   int          num_errors = 0, n_compared = 0;
   initial forever #2.5 clk = ~clk;
   sdcpm_top sdcpm_top_inst (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
      .bank_select_low(bsl), .bank_select_high(bsh), .addr(addr),
      .burst_len_cfg(bl_cfg), .interleave_cfg(1'b1),
      .cas_latency_cfg(cl_cfg), .col_ready(col_ready),
      .col_valid(col_valid), .col_bank(col_bank), .col_addr(col_addr),
      .col_is_write(col_is_write), .bank_open(bank_open),
      .bank_precharging(bank_pre), .power_mode(power_mode),
      .burst_busy(burst_busy), .mode_set_pulse(ms_p),
      .refresh_pulse(rf_p));
   sdcpm_ctl_model ctl_model_inst (.clk(clk), .stall(stall), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke), .bsl(bsl),
      .bsh(bsh), .addr(addr), .col_ready(col_ready));
   // ***********
   // checking
   // ***********
   task automatic test_done();
      if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [11:0] e,
                      input logic [11:0] s);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   always @(posedge clk) begin
      n_ms <= n_ms + 4'(ms_p);
      n_rf <= n_rf + 4'(rf_p);
      pre_seen <= pre_seen | bank_pre;
      if (col_valid && col_ready)
         cmp("column beat", exp_q.size() ? exp_q.pop_front() : 12'hfff,
             {col_is_write, col_bank, col_addr});
   end
   function automatic logic [3:0] pick(input int s);
      return s == 2 ? {3'h0, burst_busy} :
             s ? {2'h0, power_mode} : bank_open;
   endfunction
   task automatic await(input int s, input logic [3:0] e);
      int i;
      for (i = 0; i < 60 && pick(s) !== e; i++) @(negedge clk);
      cmp(s == 2 ? "burst busy" : s ? "power mode" : "open banks",
          {8'h00, e}, {8'h00, pick(s)});
      if (i == 60) test_done();
   endtask
   task automatic burst(input logic [3:0] c, input logic [1:0] b,
                        input logic [11:0] a, input int bl);
      // a new command would cut a burst still pushing beats into the fifo
      await(2, 4'h0);
      for (int k = 0; k < bl; k++)
         exp_q.push_back({c == `SDCPM_CMD_WR, b, a[8:0] ^ 9'(k)});
      ctl_model_inst.cmd(c, b, a, bl + 4);
   endtask
   // ***********
   // scenarios
   // ***********
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      ctl_model_inst.cmd(`SDCPM_CMD_MRS, 2'h0, 12'h000);
      ctl_model_inst.cmd(`SDCPM_CMD_REF, 2'h0, 12'h000);
      cmp("mode and refresh pulses", 12'h011, {4'h0, n_ms, n_rf});
      ctl_model_inst.cmd(`SDCPM_CMD_ACT, 2'h1, 12'h000);
      await(0, 4'h2);
      for (int k = 0; k < 8; k++)
         ctl_model_inst.cmd({1'b1, ctl_model_inst.seed[2:0]}, 2'h1,
                            12'h400, 1);
      ctl_model_inst.cmd(`SDCPM_CMD_NOP, 2'h1, 12'h400);
      await(0, 4'h2);
      stall = 1'b0;
      for (int j = 1; j < 4; j++) begin
         bl_cfg = 3'(j);
         burst(`SDCPM_CMD_RD, 2'h1, {3'h0, ctl_model_inst.seed[8:0]},
               1 << j);
         burst(`SDCPM_CMD_WR, 2'h1, {3'h0, ctl_model_inst.seed[8:0]},
               1 << j);
      end
      // sink held off: beats must wait in the fifo and not be lost
      stall = 1'b1;
      burst(`SDCPM_CMD_RD, 2'h1, {3'h0, ctl_model_inst.seed[8:0]}, 8);
      repeat (20) @(negedge clk);
      cmp("held beat", 12'h001, {11'h000, col_valid});
      stall = 1'b0;
      bl_cfg = `SDCPM_BL4;
      for (int j = 1; j < 4; j++) begin
         cl_cfg = 2'(j);
         burst(j == 1 ? `SDCPM_CMD_WR : `SDCPM_CMD_RD, 2'h1, 12'h405,
               4);
         await(0, 4'h0);
         cmp("auto precharge", 12'h002, {8'h00, pre_seen | bank_pre});
         ctl_model_inst.cmd(`SDCPM_CMD_ACT, 2'h1, 12'h000);
      end
      for (int b = 0; b < 4; b++)
         ctl_model_inst.cmd(`SDCPM_CMD_ACT, 2'(b), 12'h000, 1);
      await(0, 4'hf);
      ctl_model_inst.cmd(`SDCPM_CMD_PRE, 2'h2, 12'h3ff);
      await(0, 4'hb);
      ctl_model_inst.cmd(`SDCPM_CMD_PRE, 2'h0, 12'h400);
      await(0, 4'h0);
      ctl_model_inst.cmd(`SDCPM_CMD_ACT, 2'h0, 12'h000);
      await(0, 4'h1);
      ctl_model_inst.cmd(`SDCPM_CMD_NOP, 2'h0, 12'h000, 4, 1'b0);
      await(1, `SDCPM_MD_SUSPEND);
      ctl_model_inst.cmd(`SDCPM_CMD_PRE, 2'h0, 12'h400, 4, 1'b0);
      ctl_model_inst.cmd(`SDCPM_CMD_NOP, 2'h0, 12'h000);
      await(1, `SDCPM_MD_NORMAL);
      await(0, 4'h1);
      ctl_model_inst.cmd(`SDCPM_CMD_PRE, 2'h0, 12'h000);
      ctl_model_inst.cmd(`SDCPM_CMD_NOP, 2'h0, 12'h000, 4, 1'b0);
      await(1, `SDCPM_MD_PDOWN);
      ctl_model_inst.cmd(`SDCPM_CMD_NOP, 2'h0, 12'h000);
      await(1, `SDCPM_MD_NORMAL);
      for (int k = 0; k < 4096; k++)
         ctl_model_inst.cmd(`SDCPM_CMD_REF, 2'h0, 12'h000, 1);
      ctl_model_inst.cmd(`SDCPM_CMD_REF, 2'h0, 12'h000, 4, 1'b0);
      await(1, `SDCPM_MD_SELFREF);
      ctl_model_inst.cmd(`SDCPM_CMD_ACT, 2'h0, 12'h000, 4, 1'b0);
      ctl_model_inst.cmd(`SDCPM_CMD_NOP, 2'h0, 12'h000, 8);
      await(1, `SDCPM_MD_NORMAL);
      await(0, 4'h0);
      for (int k = 0; k < 4096; k++)
         ctl_model_inst.cmd(`SDCPM_CMD_REF, 2'h0, 12'h000, 4);
      cmp("refresh pulses", 12'h001, {8'h00, n_rf});
      cmp("beats left", 12'h000, 12'(exp_q.size()));
      test_done();
   end
endmodule
`default_nettype wire
